// ==== dmbsd_assertions.sv ====
// Concurrent checks on the ports of the data memory decoder.
`timescale 1ns/1ps
module dmbsd_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Request and answers.
  input wire dmbsd_pkg::dmbsd_req_t req,
  input wire logic ext_sfr_sel,
  input wire logic ext_sfr_we,
  input wire logic [7:0] ext_sfr_wdata,
  input wire logic [7:0] ext_sfr_rdata,
  input wire logic [7:0] rdata_q,
  input wire logic [7:0] stack_pointer_q,
  input wire logic [7:0] program_status_word_q,
  input wire logic [1:0] active_bank
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Direct plain accesses, and those that leave for the outside register space.
  wire logic dir = req.valid && req.mode == dmbsd_pkg::DMBSD_MODE_DIRECT && req.stk == dmbsd_pkg::DMBSD_STK_NONE;
  wire logic ext = dir && req.addr[7] && req.addr != 8'h81 && req.addr != 8'hd0;
  wire logic push = req.valid && req.stk == dmbsd_pkg::DMBSD_STK_PUSH;
  a_bank_select: assert property (active_bank == program_status_word_q[4:3]) else $error("bank mismatch");
  a_sp_reset: assert property ($rose(arst_n) |-> stack_pointer_q == 8'h07) else $error("pointer reset");
  a_push_incr: assert property (push |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01) else $error("push");
  a_direct_ext: assert property (ext |-> ext_sfr_sel) else $error("direct high not routed");
  a_low_ram: assert property (dir && !req.addr[7] |-> !ext_sfr_sel) else $error("low byte routed out");
  a_indirect_ram: assert property (req.valid && req.mode == dmbsd_pkg::DMBSD_MODE_INDIRECT |-> !ext_sfr_sel)
    else $error("indirect routed out");
  a_ext_write: assert property (ext && req.write |-> ext_sfr_we && ext_sfr_wdata == req.wdata)
    else $error("outside write");
  a_ext_read: assert property (ext && !req.write |=> rdata_q == $past(ext_sfr_rdata)) else $error("outside read");
  a_sp_read: assert property (dir && !req.write && req.addr == 8'h81 |=> rdata_q == $past(stack_pointer_q))
    else $error("pointer read");
  c_push: cover property (push);
  c_ext: cover property (ext);
  c_bit: cover property (req.valid && req.mode == dmbsd_pkg::DMBSD_MODE_BIT);
  c_indirect: cover property (req.valid && req.mode == dmbsd_pkg::DMBSD_MODE_INDIRECT && req.addr == 8'h00);
endmodule : dmbsd_assertions
bind dmbsd_top dmbsd_assertions u_chk (.core_clk(core_clk), .arst_n(arst_n), .req(req), .ext_sfr_sel(ext_sfr_sel),
  .ext_sfr_we(ext_sfr_we), .ext_sfr_wdata(ext_sfr_wdata), .ext_sfr_rdata(ext_sfr_rdata), .rdata_q(rdata_q),
  .stack_pointer_q(stack_pointer_q), .program_status_word_q(program_status_word_q), .active_bank(active_bank));

// ==== dmbsd_params.svh ====
// Address map constants, field positions and reset values for the data memory decoder.
`ifndef DMBSD_PARAMS_SVH
`define DMBSD_PARAMS_SVH
`define DMBSD_SP_ADDR 8'h81
`define DMBSD_PSW_ADDR 8'hd0
`define DMBSD_SP_RESET 8'h07
`define DMBSD_PSW_RESET 8'h00
`define DMBSD_RS0_BIT 3
`define DMBSD_RS1_BIT 4
`define DMBSD_BITAREA_BASE 8'h20
`define DMBSD_SFR_BASE 8'h80
`define DMBSD_BANK_SHIFT 3
`endif

// ==== dmbsd_pkg.sv ====
// Types shared by the data memory decoder files.
package dmbsd_pkg;
  // Addressing mode of an access, one-hot.
  typedef enum logic [3:0] {
    DMBSD_MODE_REG = 4'h1,
    DMBSD_MODE_DIRECT = 4'h2,
    DMBSD_MODE_INDIRECT = 4'h4,
    DMBSD_MODE_BIT = 4'h8
  } dmbsd_mode_t;

  // Operation on the stack pointer.
  typedef enum logic [2:0] {
    DMBSD_STK_NONE = 3'h1,
    DMBSD_STK_PUSH = 3'h2,
    DMBSD_STK_POP = 3'h4
  } dmbsd_stk_t;

  // One access request from the execution unit.
  typedef struct packed {
    logic valid;
    logic write;
    dmbsd_mode_t mode;
    dmbsd_stk_t stk;
    logic [7:0] addr;
    logic [2:0] reg_num;
    logic [7:0] wdata;
    logic wbit;
  } dmbsd_req_t;
endpackage : dmbsd_pkg

// ==== dmbsd_ram.sv ====
// Internal data RAM with upper and lower halves in one 256-byte array.
`timescale 1ns/1ps
module dmbsd_ram #(
  parameter int DEPTH = 256
) (
  // Clock.
  input wire logic core_clk,
  // Port.
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata,
  // Index register fetch port.
  input wire logic [7:0] paddr,
  output logic [7:0] pdata
);
  initial begin
    if (DEPTH != 256) begin
      $error("dmbsd_ram needs DEPTH of 256");
    end
  end

  logic [7:0] mem [DEPTH];

  // Write port; contents are not reset, as in any data RAM.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Asynchronous read lets the core do read-modify-write in one cycle.
  assign rdata = mem[raddr];

  // Second asynchronous read, so an indirect access can fetch its pointer and its target in one cycle.
  assign pdata = mem[paddr];
endmodule : dmbsd_ram

// ==== dmbsd_sfr_model.sv ====
// Behavioural model of the outside special register space.
`timescale 1ns/1ps
module dmbsd_sfr_model (
  // Clock.
  input wire logic core_clk,
  // Register access from the decoder.
  input wire logic ext_sfr_sel,
  input wire logic ext_sfr_we,
  input wire logic [7:0] ext_sfr_addr,
  input wire logic [7:0] ext_sfr_wdata,
  output logic [7:0] ext_sfr_rdata
);
  logic [7:0] mem_q [256];
  // Writes land at the edge; reads answer in the same cycle.
  always_ff @(posedge core_clk) begin
    if (ext_sfr_sel && ext_sfr_we) begin
      mem_q[ext_sfr_addr] <= ext_sfr_wdata;
    end
  end
  // Unselected, the bus shows the inverse so that a stale value never passes.
  assign ext_sfr_rdata = ext_sfr_sel ? mem_q[ext_sfr_addr] : ~mem_q[ext_sfr_addr];
endmodule : dmbsd_sfr_model

// ==== dmbsd_top.sv ====
// Data memory bank, bit, stack and special register decoder.
`timescale 1ns/1ps
`include "dmbsd_params.svh"
module dmbsd_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Access request from the execution unit.
  input wire dmbsd_pkg::dmbsd_req_t req,
  // Outside special register space.
  output logic ext_sfr_sel,
  output logic ext_sfr_we,
  output logic [7:0] ext_sfr_addr,
  output logic [7:0] ext_sfr_wdata,
  input wire logic [7:0] ext_sfr_rdata,
  // Answer.
  output logic [7:0] rdata_q,
  output logic rbit_q,
  output logic [7:0] stack_pointer_q,
  output logic [7:0] program_status_word_q,
  output logic [1:0] active_bank
);
  logic [7:0] eff_addr;
  logic is_sfr;
  logic bit_mode;
  logic [2:0] bit_pos;
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic [7:0] ptr_addr;
  logic [7:0] ptr_data;
  logic [7:0] ram_waddr;
  logic ram_we;
  logic [7:0] cur_byte;
  logic [7:0] new_byte;
  logic [7:0] stack_pointer_d;
  logic [7:0] program_status_word_d;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------

  // Active bank from the two select bits.
  assign active_bank = {program_status_word_q[`DMBSD_RS1_BIT], program_status_word_q[`DMBSD_RS0_BIT]};

  // Index register address, looked up first so indirect modes can use it.
  // It has a read port of its own on the RAM; sharing the main port would make the
  // target address depend on the data read at that same address, a combinational loop.
  assign ptr_addr = {3'h0, active_bank, 2'h0, req.reg_num[0]};

  // Bit-or-byte comes only from the mode, never the address.
  assign bit_mode = (req.mode == dmbsd_pkg::DMBSD_MODE_BIT);
  assign bit_pos = req.addr[2:0];

  // Effective byte address and space choice per mode.
  always_comb begin
    eff_addr = 8'h00;
    is_sfr = 1'b0;
    unique case (req.mode)
      dmbsd_pkg::DMBSD_MODE_REG: begin
        eff_addr = {3'h0, active_bank, req.reg_num};
      end
      dmbsd_pkg::DMBSD_MODE_DIRECT: begin
        eff_addr = req.addr;
        is_sfr = req.addr[7];
      end
      dmbsd_pkg::DMBSD_MODE_INDIRECT: begin
        // The upper half of the RAM is reachable this way and through stack operations.
        // Direct addresses above 0x7f never land in RAM.
        eff_addr = ptr_data;
        is_sfr = 1'b0;
      end
      dmbsd_pkg::DMBSD_MODE_BIT: begin
        if (req.addr[7]) begin
          eff_addr = {req.addr[7:3], 3'h0};
          is_sfr = 1'b1;
        end else begin
          eff_addr = `DMBSD_BITAREA_BASE + {4'h0, req.addr[6:3]};
        end
      end
      default: begin
        eff_addr = 8'h00;
      end
    endcase
    // Stack operations address the full RAM through the pointer.
    if (req.stk == dmbsd_pkg::DMBSD_STK_PUSH) begin
      eff_addr = stack_pointer_q + 8'h01;
      is_sfr = 1'b0;
    end else if (req.stk == dmbsd_pkg::DMBSD_STK_POP) begin
      eff_addr = stack_pointer_q;
      is_sfr = 1'b0;
    end
  end

  // The main RAM read port always serves the effective address.
  // Bit writes to the bit area use it for their read-modify-write.
  assign ram_raddr = eff_addr;

  // The pointer port keeps the index fetch apart from the data read.
  dmbsd_ram #(
    .DEPTH(256)
  ) u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(new_byte),
    .raddr(ram_raddr),
    .rdata(ram_rdata),
    .paddr(ptr_addr),
    .pdata(ptr_data)
  );

  // ------------------------------------------------------------
  // Data path
  // ------------------------------------------------------------

  // Current byte from the chosen space; local registers win over the outside.
  always_comb begin
    cur_byte = 8'h00;
    if (is_sfr) begin
      if (eff_addr == `DMBSD_SP_ADDR) begin
        cur_byte = stack_pointer_q;
      end else if (eff_addr == `DMBSD_PSW_ADDR) begin
        cur_byte = program_status_word_q;
      end else begin
        cur_byte = ext_sfr_rdata;
      end
    end else begin
      cur_byte = ram_rdata;
    end
  end

  // Bit writes merge one bit into the byte; byte writes replace it.
  always_comb begin
    new_byte = req.wdata;
    if (bit_mode) begin
      new_byte = cur_byte;
      new_byte[bit_pos] = req.wbit;
    end
  end

  // Every write outside the special register space lands in RAM at the effective address.
  // Indirect writes need no extra cycle, since the pointer comes from its own port.
  // A write through an index register to the index register itself is allowed; the new value counts next cycle.
  assign ram_we = req.valid && req.write && !is_sfr;
  assign ram_waddr = eff_addr;

  // Outside special register strobes, excluding the two held here.
  assign ext_sfr_sel = req.valid && is_sfr && eff_addr != `DMBSD_SP_ADDR && eff_addr != `DMBSD_PSW_ADDR;
  assign ext_sfr_we = ext_sfr_sel && req.write;
  assign ext_sfr_addr = eff_addr;
  assign ext_sfr_wdata = new_byte;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------

  // Stack pointer: push pre-increments, pop post-decrements, direct write loads.
  // Limitation: the pointer wraps from 0xff to 0x00 with no guard, so an overflowing stack
  // silently overwrites bank zero; software must size the stack.
  always_comb begin
    stack_pointer_d = stack_pointer_q;
    if (req.valid && req.stk == dmbsd_pkg::DMBSD_STK_PUSH) begin
      stack_pointer_d = stack_pointer_q + 8'h01;
    end else if (req.valid && req.stk == dmbsd_pkg::DMBSD_STK_POP) begin
      stack_pointer_d = stack_pointer_q - 8'h01;
    end else if (req.valid && req.write && is_sfr && eff_addr == `DMBSD_SP_ADDR) begin
      stack_pointer_d = new_byte;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_pointer_q <= `DMBSD_SP_RESET;
    end else begin
      stack_pointer_q <= stack_pointer_d;
    end
  end

  // Status word written as a byte or a bit; flags come from outside writes.
  assign program_status_word_d = (req.valid && req.write && is_sfr && eff_addr == `DMBSD_PSW_ADDR) ?
      new_byte : program_status_word_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      program_status_word_q <= `DMBSD_PSW_RESET;
    end else begin
      program_status_word_q <= program_status_word_d;
    end
  end

  // Registered answer so the data outputs come from flip-flops.
  // The bit output is only meaningful after a bit-mode read; a byte read updates it too.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
    end else if (req.valid && !req.write) begin
      rdata_q <= cur_byte;
      rbit_q <= cur_byte[bit_pos];
    end
  end
endmodule : dmbsd_top

// ==== tb.sv ====
// Self-checking bench for the data memory decoder.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  dmbsd_pkg::dmbsd_req_t req = '0;
  logic ext_sfr_sel, ext_sfr_we;
  logic [7:0] ext_sfr_addr, ext_sfr_wdata, ext_sfr_rdata, rdata_q, rnd, a, b, sp_seen, seen;
  logic rbit_q;
  localparam logic [7:0] bit_a [3] = '{8'h07, 8'h13, 8'h7f};
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] exp_q [$];
  always #20 core_clk = ~core_clk;
  dmbsd_top dut (.core_clk(core_clk), .arst_n(arst_n), .req(req), .ext_sfr_sel(ext_sfr_sel), .ext_sfr_we(ext_sfr_we),
    .ext_sfr_addr(ext_sfr_addr), .ext_sfr_wdata(ext_sfr_wdata), .ext_sfr_rdata(ext_sfr_rdata), .rdata_q(rdata_q),
    .rbit_q(rbit_q), .stack_pointer_q(sp_seen), .program_status_word_q(), .active_bank());
  dmbsd_sfr_model sfr (.core_clk(core_clk), .ext_sfr_sel(ext_sfr_sel), .ext_sfr_we(ext_sfr_we),
    .ext_sfr_addr(ext_sfr_addr), .ext_sfr_wdata(ext_sfr_wdata), .ext_sfr_rdata(ext_sfr_rdata));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One request per cycle, held until the next falling edge; reads note their answer.
  task automatic acc(input logic w, input dmbsd_pkg::dmbsd_mode_t m, input dmbsd_pkg::dmbsd_stk_t s,
    input logic [7:0] ad, input logic [7:0] d, input logic [7:0] e);
    @(negedge core_clk);
    req <= '{1'b1, w, m, s, ad, ad[2:0], d, d[0]};
    if (!w) exp_q.push_back(e);
  endtask : acc
  task automatic dw(input logic [7:0] ad, input logic [7:0] d);
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_NONE, ad, d, 8'h00);
  endtask : dw
  task automatic dr(input logic [7:0] ad, input logic [7:0] e);
    acc(1'b0, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_NONE, ad, 8'h00, e);
  endtask : dr
  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // The read answer lands one edge after the request; compare once it has settled.
  // Bit-mode reads are judged on the bit output, byte reads on the byte output.
  always @(posedge core_clk) begin
    if (arst_n && req.valid && !req.write) begin
      #1;
      seen = (req.mode == dmbsd_pkg::DMBSD_MODE_BIT) ? {7'h00, rbit_q} : rdata_q;
      if (exp_q.size() == 0) check("queue", 8'h00, 8'hff);
      else check("rdata_q", exp_q.pop_front(), seen);
    end
  end
  // Only occupied outside addresses are touched, since the others are undefined.
  initial begin
    rnd = 8'h12;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) arst_n <= 1'b1;
    dr(8'h81, 8'h07);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      dw(8'hd0, 8'(k << 3));
      acc(1'b1, dmbsd_pkg::DMBSD_MODE_REG, dmbsd_pkg::DMBSD_STK_NONE, 8'(k + 4), rnd, 8'h00);
      dr(8'(9 * k + 4), rnd);
    end
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_PUSH, 8'h08, 8'h5a, 8'h00);
    dr(8'h08, 8'h5a);
    dr(8'h81, 8'h08);
    dw(8'h81, 8'hfd);
    a = lfsr(rnd);
    b = lfsr(a);
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_PUSH, 8'hfe, a, 8'h00);
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_PUSH, 8'hff, b, 8'h00);
    acc(1'b0, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_POP, 8'hff, 8'h00, b);
    acc(1'b0, dmbsd_pkg::DMBSD_MODE_DIRECT, dmbsd_pkg::DMBSD_STK_POP, 8'hfe, 8'h00, a);
    dr(8'h81, 8'hfd);
    // Mid-run reset: the pointer must return to its reset value after being moved.
    @(negedge core_clk) begin
      req <= '0;
      arst_n <= 1'b0;
    end
    @(negedge core_clk) arst_n <= 1'b1;
    check("stack_pointer_q", 8'h07, sp_seen);
    dr(8'h81, 8'h07);
    foreach (bit_a[i]) begin
      dw(8'h20 + {4'h0, bit_a[i][6:3]}, 8'h00);
      acc(1'b1, dmbsd_pkg::DMBSD_MODE_BIT, dmbsd_pkg::DMBSD_STK_NONE, bit_a[i], 8'h01, 8'h00);
      dr(8'h20 + {4'h0, bit_a[i][6:3]}, 8'h01 << bit_a[i][2:0]);
      acc(1'b0, dmbsd_pkg::DMBSD_MODE_BIT, dmbsd_pkg::DMBSD_STK_NONE, bit_a[i], 8'h00, 8'h01);
      acc(1'b0, dmbsd_pkg::DMBSD_MODE_BIT, dmbsd_pkg::DMBSD_STK_NONE, bit_a[i] ^ 8'h01, 8'h00, 8'h00);
    end
    dw(8'h90, b);
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_BIT, dmbsd_pkg::DMBSD_STK_NONE, 8'h93, 8'h01, 8'h00);
    dr(8'h90, b | 8'h08);
    acc(1'b0, dmbsd_pkg::DMBSD_MODE_BIT, dmbsd_pkg::DMBSD_STK_NONE, 8'h93, 8'h00, 8'h01);
    // Indirect through the first index register of bank zero into the upper RAM half.
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_REG, dmbsd_pkg::DMBSD_STK_NONE, 8'h00, 8'h90, 8'h00);
    acc(1'b1, dmbsd_pkg::DMBSD_MODE_INDIRECT, dmbsd_pkg::DMBSD_STK_NONE, 8'h00, a, 8'h00);
    acc(1'b0, dmbsd_pkg::DMBSD_MODE_INDIRECT, dmbsd_pkg::DMBSD_STK_NONE, 8'h00, 8'h00, a);
    dr(8'h90, b | 8'h08);
    @(negedge core_clk) req <= '0;
    repeat (2) @(posedge core_clk);
    check("queue", 8'h00, 8'(exp_q.size()));
    tally_and_finish();
  end
endmodule : tb
